// *** src/nfc_pkg.sv ***
// constants for the nor flash host command controller
package nfc_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 16;
   // bus timing in ns, converted to core_clk cycles (20 ns)
   localparam int CLK_NS        = 20;
   localparam int T_SETUP_NS    = 40;
   localparam int T_PULSE_NS    = 60;
   localparam int T_HOLD_NS     = 40;
   localparam int T_READ_NS     = 90;
   localparam int SETUP_CYC     = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int PULSE_CYC     = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC      = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_CYC      = (T_READ_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int CNT_W         = 8;
   // command codes and unlock addresses
   localparam logic [7:0]  CMD_UNLOCK_A   = 8'hAA;
   localparam logic [7:0]  CMD_UNLOCK_B   = 8'h55;
   localparam logic [7:0]  CMD_PROGRAM    = 8'hA0;
   localparam logic [7:0]  CMD_ERASE_PRE  = 8'h80;
   localparam logic [7:0]  CMD_SECTOR_ER  = 8'h30;
   localparam logic [7:0]  CMD_BLOCK_ER   = 8'h50;
   localparam logic [7:0]  CMD_CHIP_ER    = 8'h10;
   localparam logic [18:0] ADDR_UNLOCK_A  = 19'h0_5555;
   localparam logic [18:0] ADDR_UNLOCK_B  = 19'h0_2AAA;
   // address field positions
   localparam int SECTOR_LSB = 11;
   localparam int BLOCK_LSB  = 15;
   // user operation codes
   typedef enum logic [2:0] {
      NFC_OP_READ, NFC_OP_PROGRAM, NFC_OP_SECTOR, NFC_OP_BLOCK, NFC_OP_CHIP
   } nfc_op_t;
   localparam logic [2:0] SEQ_PROG_LEN  = 3'd4;
   localparam logic [2:0] SEQ_ERASE_LEN = 3'd6;
   localparam logic [1:0] RECHECK_READS = 2'd2;
endpackage : nfc_pkg

// *** src/nfc_sync.sv ***
// two flip-flop synchroniser for the flash data pins
`timescale 1ns/1ps
module nfc_sync #(
   parameter int WIDTH = 16
) (
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;
endmodule // nfc_sync

// *** src/nfc_host.sv ***
// host controller driving a parallel nor flash through its pins
// Rules of the flash device
// [R1] host writes each command cycle with write strobe low while chip select low
// [R2] device latches address when later of strobe or select falls
// [R3] device latches data when first of strobe or select rises
// [R4] device sleeps after read, wakes on new read without delay
// [R5] read data only while chip select and output gate both low
// [R6] device floats data when chip select or output gate high
// [R7] chip select high deselects device, bus activity ignored
// [R8] program is three unlock cycles then address and data cycle
// [R9] internal program finishes within 20 us
// [R10] during program only status reads are meaningful
// [R11] commands during internal program are ignored
// [R12] sector erase six cycles, last carries 30h, sector on A11-A18
// [R13] block erase six cycles, last carries 50h, block on A15-A18
// [R14] erase address latched on sixth falling edge, code on rising
// [R15] sector or block erase starts after sixth strobe, commands ignored
// [R16] chip erase six cycles, last writes 10h to 5555h
// [R17] chip erase starts at sixth strobe rise, commands ignored
// [R18] during erase only status bits are meaningful
// [R19] device gives polling and toggling completion bits after launching strobe
// [R20] on apparent conflict host reads twice more, both must be valid
// [R21] polling bit reads inverse data during program, true after
// [R22] polling bit reads zero during erase, one after
// [R23] toggling bit alternates during operation, stops when done
// [R24] invalid cycle aborts sequence, upper data lanes ignored
// [R25] device alters nothing without full correct unlock and command
`timescale 1ns/1ps
module nfc_host
   import nfc_pkg::*;
#(
   parameter int ADDR_WIDTH = nfc_pkg::ADDR_W,
   parameter int DATA_WIDTH = nfc_pkg::DATA_W
) (
   input  wire logic                  core_clk,
   input  wire logic                  sys_rst,
   // user side
   input  wire logic                  req_valid,
   input  wire nfc_pkg::nfc_op_t      req_op,
   input  wire logic [ADDR_WIDTH-1:0] req_addr,
   input  wire logic [DATA_WIDTH-1:0] req_wdata,
   output logic                       req_ready,
   output logic                       rsp_valid,
   output logic [DATA_WIDTH-1:0]      rsp_rdata,
   // flash pins
   output logic                       chip_sel_n,
   output logic                       out_gate_n,
   output logic                       wr_strobe_n,
   output logic [ADDR_WIDTH-1:0]      flash_addr,
   output logic [DATA_WIDTH-1:0]      flash_dq_out,
   output logic                       flash_dq_oe_n,
   input  wire logic [DATA_WIDTH-1:0] flash_dq_in
);
   import nfc_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE, ST_WSETUP, ST_WPULSE, ST_WHOLD, ST_NEXT,
      ST_RSETUP, ST_RWAIT, ST_RDONE, ST_POLL, ST_POLLGAP
   } nfc_state_t;

   nfc_state_t            state_reg, state_next;
   nfc_op_t               op_reg;
   logic [ADDR_WIDTH-1:0] uaddr_reg;
   logic [DATA_WIDTH-1:0] udata_reg;
   logic [2:0]            step_reg;
   logic [CNT_W-1:0]      cnt_reg;
   logic [DATA_WIDTH-1:0] prev_reg;
   logic                  have_prev_reg;
   logic [1:0]            recheck_reg;
   logic [DATA_WIDTH-1:0] dq_sync;

   nfc_sync #(
      .WIDTH (DATA_WIDTH)
   ) u_sync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .async_in (flash_dq_in),
      .sync_out (dq_sync)
   );

   // ----------------------------------------------------------------
   // sequence table: address and data for the current write cycle
   // ----------------------------------------------------------------
   wire       is_erase  = (op_reg == NFC_OP_SECTOR) || (op_reg == NFC_OP_BLOCK) || (op_reg == NFC_OP_CHIP);
   wire [2:0] seq_len   = is_erase ? SEQ_ERASE_LEN : SEQ_PROG_LEN;
   wire       last_step = (step_reg == seq_len - 3'd1);
   wire [7:0] last_cmd  = (op_reg == NFC_OP_SECTOR) ? CMD_SECTOR_ER :
                          (op_reg == NFC_OP_BLOCK)  ? CMD_BLOCK_ER  : CMD_CHIP_ER;
   // [R12] [R13] sector and block select fields
   wire [ADDR_WIDTH-1:0] sector_addr = (uaddr_reg >> SECTOR_LSB) << SECTOR_LSB;
   wire [ADDR_WIDTH-1:0] block_addr  = (uaddr_reg >> BLOCK_LSB) << BLOCK_LSB;
   wire [ADDR_WIDTH-1:0] erase_addr  = (op_reg == NFC_OP_SECTOR) ? sector_addr :
                                       (op_reg == NFC_OP_BLOCK)  ? block_addr  : ADDR_UNLOCK_A;
   // [R8] [R16] unlock order, command cycle, a second unlock pair for erase, then final cycle
   logic [ADDR_WIDTH-1:0] seq_addr;
   logic [7:0]            seq_byte;
   always_comb begin
      seq_addr = ADDR_UNLOCK_A;
      seq_byte = CMD_UNLOCK_A;
      case (step_reg)
         3'd0:    begin seq_addr = ADDR_UNLOCK_A; seq_byte = CMD_UNLOCK_A; end
         3'd1:    begin seq_addr = ADDR_UNLOCK_B; seq_byte = CMD_UNLOCK_B; end
         3'd2:    begin seq_addr = ADDR_UNLOCK_A; seq_byte = is_erase ? CMD_ERASE_PRE : CMD_PROGRAM; end
         3'd3:    begin
            seq_addr = is_erase ? ADDR_UNLOCK_A : uaddr_reg;
            seq_byte = is_erase ? CMD_UNLOCK_A : udata_reg[7:0];
         end
         3'd4:    begin seq_addr = ADDR_UNLOCK_B; seq_byte = CMD_UNLOCK_B; end
         3'd5:    begin seq_addr = erase_addr; seq_byte = last_cmd; end
         default: begin seq_addr = ADDR_UNLOCK_A; seq_byte = CMD_UNLOCK_A; end
      endcase
   end
   // [R24] upper lanes zero on command cycles, full word on program data
   wire prog_data = !is_erase && last_step;
   wire [DATA_WIDTH-1:0] seq_word = prog_data ? udata_reg : {{(DATA_WIDTH-8){1'b0}}, seq_byte};

   // ----------------------------------------------------------------
   // completion polling
   // ----------------------------------------------------------------
   // [R21] [R22] expected final value of the polling bit
   wire poll_target = is_erase ? 1'b1 : udata_reg[7];
   // [R23] toggling bit stopped between two consecutive reads
   wire toggle_stop = have_prev_reg && (prev_reg[6] == dq_sync[6]);
   wire status_done = toggle_stop && (dq_sync[7] == poll_target);
   wire cnt_done    = (cnt_reg == '0);
   // [R21] [R22] answer word
   // the pins float once the gate rises, so a finished poll answers with its last gated read
   wire [DATA_WIDTH-1:0] rsp_word = (op_reg == NFC_OP_READ) ? dq_sync : prev_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:    if (req_valid) state_next = (req_op == NFC_OP_READ) ? ST_RSETUP : ST_WSETUP;
         ST_WSETUP:  if (cnt_done) state_next = ST_WPULSE;
         ST_WPULSE:  if (cnt_done) state_next = ST_WHOLD;
         ST_WHOLD:   if (cnt_done) state_next = ST_NEXT;
         ST_NEXT:    state_next = last_step ? ST_POLL : ST_WSETUP;
         ST_RSETUP:  state_next = ST_RWAIT;
         ST_RWAIT:   if (cnt_done) state_next = ST_RDONE;
         ST_RDONE:   state_next = ST_IDLE;
         ST_POLL:    if (cnt_done) state_next = ST_POLLGAP;
         // [R20] after done seen, two more reads must agree
         ST_POLLGAP: state_next = (status_done && recheck_reg == RECHECK_READS) ? ST_RDONE : ST_POLL;
         default:    state_next = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // state, counters and pins
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_reg     <= ST_IDLE;
         op_reg        <= NFC_OP_READ;
         uaddr_reg     <= '0;
         udata_reg     <= '0;
         step_reg      <= '0;
         cnt_reg       <= '0;
         prev_reg      <= '0;
         have_prev_reg <= 1'b0;
         recheck_reg   <= '0;
         req_ready     <= 1'b0;
         rsp_valid     <= 1'b0;
         rsp_rdata     <= '0;
         chip_sel_n    <= 1'b1;
         out_gate_n    <= 1'b1;
         wr_strobe_n   <= 1'b1;
         flash_addr    <= '0;
         flash_dq_out  <= '0;
         flash_dq_oe_n <= 1'b1;
      end else begin
         state_reg <= state_next;
         rsp_valid <= 1'b0;
         req_ready <= (state_next == ST_IDLE) && !(state_reg == ST_IDLE && req_valid);
         if (!cnt_done) cnt_reg <= cnt_reg - 1'b1;
         case (state_reg)
            ST_IDLE: if (req_valid) begin
               op_reg    <= req_op;
               uaddr_reg <= req_addr;
               udata_reg <= req_wdata;
               step_reg  <= '0;
               req_ready <= 1'b0;
               cnt_reg   <= CNT_W'(SETUP_CYC);
               // [R7] select held high while idle
               chip_sel_n <= 1'b0;
            end
            ST_WSETUP: begin
               // [R2] address stable before strobe falls
               flash_addr    <= seq_addr;
               flash_dq_out  <= seq_word;
               flash_dq_oe_n <= 1'b0;
               out_gate_n    <= 1'b1;
               if (cnt_done) begin
                  // [R1] strobe low with select low
                  wr_strobe_n <= 1'b0;
                  cnt_reg     <= CNT_W'(PULSE_CYC);
               end
            end
            ST_WPULSE: if (cnt_done) begin
               // [R3] [R14] data held across strobe rise
               wr_strobe_n <= 1'b1;
               cnt_reg     <= CNT_W'(HOLD_CYC);
            end
            ST_WHOLD: if (cnt_done) flash_dq_oe_n <= 1'b1;
            ST_NEXT: begin
               step_reg <= step_reg + 3'd1;
               cnt_reg  <= CNT_W'(last_step ? READ_CYC : SETUP_CYC);
               // [R19] [R11] [R15] [R17] only status reads until done
               if (last_step) begin
                  out_gate_n    <= 1'b0;
                  have_prev_reg <= 1'b0;
                  recheck_reg   <= '0;
               end
            end
            ST_RSETUP: begin
               // [R5] [R6] both low, own drivers released
               flash_addr    <= uaddr_reg;
               flash_dq_oe_n <= 1'b1;
               out_gate_n    <= 1'b0;
               cnt_reg       <= CNT_W'(READ_CYC);
            end
            ST_RDONE: begin
               rsp_valid  <= 1'b1;
               rsp_rdata  <= rsp_word;
               // [R4] release bus so device may drop to low power
               chip_sel_n <= 1'b1;
               out_gate_n <= 1'b1;
            end
            ST_POLL: if (cnt_done) out_gate_n <= 1'b1;
            ST_POLLGAP: begin
               // [R10] [R18] [R9] poll status until both bits settle
               prev_reg      <= dq_sync;
               have_prev_reg <= 1'b1;
               if (status_done) begin
                  if (recheck_reg != RECHECK_READS) recheck_reg <= recheck_reg + 2'd1;
               end else begin
                  recheck_reg <= '0;
               end
               if (!(status_done && recheck_reg == RECHECK_READS)) begin
                  out_gate_n <= 1'b0;
                  cnt_reg    <= CNT_W'(READ_CYC);
               end
            end
            default: ;
         endcase
      end
   end
endmodule // nfc_host

// *** tb/nfc_host_chk.sv ***
// pin-level assertions for the nor flash host controller
`timescale 1ns/1ps
module nfc_host_chk #(
   parameter int ADDR_WIDTH = 19,
   parameter int DATA_WIDTH = 16
) (
   input wire logic                  core_clk,
   input wire logic                  sys_rst,
   input wire logic                  req_ready,
   input wire logic                  rsp_valid,
   input wire logic                  chip_sel_n,
   input wire logic                  out_gate_n,
   input wire logic                  wr_strobe_n,
   input wire logic [ADDR_WIDTH-1:0] flash_addr,
   input wire logic [DATA_WIDTH-1:0] flash_dq_out,
   input wire logic                  flash_dq_oe_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   property p_strobe_sel; !wr_strobe_n |-> !chip_sel_n; endproperty
   a_strobe_sel: assert property (p_strobe_sel) else $error("strobe low without select");
   property p_no_fight; !out_gate_n |-> flash_dq_oe_n && wr_strobe_n; endproperty
   a_no_fight: assert property (p_no_fight) else $error("host drives dq while gated");
   property p_setup; $fell(wr_strobe_n) |-> !$past(flash_dq_oe_n) && $stable(flash_addr) && out_gate_n; endproperty
   a_setup: assert property (p_setup) else $error("address or data not set up");
   property p_hold; !wr_strobe_n && !$past(wr_strobe_n) |-> $stable(flash_addr) && $stable(flash_dq_out); endproperty
   a_hold: assert property (p_hold) else $error("address moved in strobe");
   property p_data_rise; $rose(wr_strobe_n) |-> !flash_dq_oe_n && $stable(flash_dq_out); endproperty
   a_data_rise: assert property (p_data_rise) else $error("data not held at strobe rise");
   property p_pulse; $fell(wr_strobe_n) |-> !wr_strobe_n [*4] ##1 wr_strobe_n; endproperty
   a_pulse: assert property (p_pulse) else $error("strobe pulse width wrong");
   property p_rsp_pulse; rsp_valid |=> !rsp_valid; endproperty
   a_rsp_pulse: assert property (p_rsp_pulse) else $error("answer longer than one cycle");
   property p_rst_idle; $fell(sys_rst) |-> chip_sel_n && flash_dq_oe_n && !req_ready ##1 req_ready; endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("pins not idle after reset");
   c_write: cover property ($rose(wr_strobe_n));
   c_gate: cover property ($fell(out_gate_n));
   c_answer: cover property (rsp_valid);
endmodule // nfc_host_chk

bind nfc_host nfc_host_chk #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)) u_chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .req_ready(req_ready), .rsp_valid(rsp_valid),
   .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n),
   .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n));

// *** tb/nfc_flash_model.sv ***
// behavioural nor flash device facing the host controller
`timescale 1ns/1ps
module nfc_flash_model
   import nfc_pkg::*;
#(
   parameter int PROG_NS  = 2000,
   parameter int ERASE_NS = 4000
) (
   input  wire logic        chip_sel_n,
   input  wire logic        out_gate_n,
   input  wire logic        wr_strobe_n,
   input  wire logic [18:0] flash_addr,
   input  wire logic [15:0] flash_dq_out,
   input  wire logic        flash_dq_oe_n,
   output logic      [15:0] flash_dq_in
);
   logic [15:0] mem [0:524287];
   logic [18:0] lat_addr;
   logic [15:0] last_val, rd_val, prog_val;
   logic        busy, erasing, tog;
   int          step;
   initial begin
      foreach (mem[i]) mem[i] = 16'hFFFF;
      {busy, erasing, tog, step, last_val, prog_val} = '0;
   end
   task automatic launch(input logic er, input int ns);
      busy = 1'b1;
      erasing = er;
      fork begin #(ns) busy = 1'b0; end join_none
   endtask
   task automatic command(input logic [18:0] a, input logic [15:0] d);
      case (step)
         0, 3: step = (a == ADDR_UNLOCK_A && d[7:0] == CMD_UNLOCK_A) ? step + 1 : 0;
         1, 4: step = (a == ADDR_UNLOCK_B && d[7:0] == CMD_UNLOCK_B) ? step + 1 : 0;
         2: step = (a != ADDR_UNLOCK_A) ? 0 : (d[7:0] == CMD_PROGRAM) ? 9 : (d[7:0] == CMD_ERASE_PRE) ? 3 : 0;
         9: begin
            mem[a] = d;
            prog_val = d;
            step = 0;
            launch(1'b0, PROG_NS);
         end
         5: begin
            step = 0;
            if (d[7:0] == CMD_SECTOR_ER || d[7:0] == CMD_BLOCK_ER || (d[7:0] == CMD_CHIP_ER && a == ADDR_UNLOCK_A)) begin
               foreach (mem[i])
                  if (d[7:0] == CMD_SECTOR_ER ? (i >> 11) == a[18:11] :
                      d[7:0] == CMD_BLOCK_ER ? (i >> 15) == a[18:15] : 1'b1) mem[i] = 16'hFFFF;
               launch(1'b1, ERASE_NS);
            end
         end
         default: step = 0;
      endcase
   endtask
   always @(negedge wr_strobe_n) if (!chip_sel_n) lat_addr = flash_addr;
   always @(posedge wr_strobe_n) if (!chip_sel_n && !flash_dq_oe_n && !busy) command(lat_addr, flash_dq_out);
   always @(negedge out_gate_n) if (!chip_sel_n && busy) tog = ~tog;
   assign rd_val = busy ? {8'h00, erasing ? 1'b0 : ~prog_val[7], tog, 6'h00} : mem[flash_addr];
   always @* if (!chip_sel_n && !out_gate_n) last_val = rd_val;
   assign flash_dq_in = (!chip_sel_n && !out_gate_n) ? rd_val : ~last_val;
endmodule // nfc_flash_model

// *** tb/nfc_host_tb.sv ***
// self-checking bench for the nor flash host controller
`timescale 1ns/1ps
module nfc_host_tb;
   import nfc_pkg::*;
   logic        core_clk, sys_rst, req_valid, req_ready, rsp_valid;
   logic        chip_sel_n, out_gate_n, wr_strobe_n, flash_dq_oe_n;
   nfc_op_t     req_op;
   logic [18:0] req_addr, flash_addr;
   logic [15:0] req_wdata, rsp_rdata, flash_dq_out, flash_dq_in, rd;
   int          num_errors, total_checks;
   logic [18:0] pa [3] = '{19'h0_0805, 19'h0_1000, 19'h4_0000};
   logic [15:0] pd [3] = '{16'h12B4, 16'h5678, 16'hA55A};
   nfc_host DUT (.core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
      .rsp_rdata(rsp_rdata), .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n),
      .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
      .flash_dq_in(flash_dq_in));
   nfc_flash_model u_flash (.chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n),
      .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
      .flash_dq_in(flash_dq_in));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic run_op(input nfc_op_t op, input logic [18:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(negedge core_clk);
      req_valid = 1'b1;
      req_op = op;
      req_addr = a;
      req_wdata = d;
      while (req_ready !== 1'b1 && n < 50) begin @(negedge core_clk); n++; end
      @(negedge core_clk);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 20000) begin @(negedge core_clk); n++; end
      if (n >= 20000) num_errors++;
      rd = rsp_rdata;
   endtask
   task automatic read_chk(input logic [18:0] a, input logic [15:0] exp);
      run_op(NFC_OP_READ, a, 16'h0000);
      check(rd, exp);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #400_000;
      num_errors++;
      report_and_stop();
   end
   initial begin
      {num_errors, total_checks} = '0;
      {sys_rst, req_valid, req_addr, req_wdata} = {1'b1, 1'b0, 19'h0_0000, 16'h0000};
      req_op = NFC_OP_READ;
      repeat (2) @(negedge core_clk);
      sys_rst = 1'b0;
      check({13'h0000, chip_sel_n, wr_strobe_n, flash_dq_oe_n}, 16'h0007);
      read_chk(19'h0_0123, 16'hFFFF);
      foreach (pa[i]) begin
         run_op(NFC_OP_PROGRAM, pa[i], pd[i]);
         check(rd, pd[i]);
         read_chk(pa[i], pd[i]);
      end
      run_op(NFC_OP_SECTOR, 19'h0_0FFF, 16'h0000);
      check(rd, 16'hFFFF);
      read_chk(pa[0], 16'hFFFF);
      read_chk(pa[1], pd[1]);
      run_op(NFC_OP_BLOCK, 19'h0_7FFF, 16'h0000);
      check(rd, 16'hFFFF);
      read_chk(pa[1], 16'hFFFF);
      read_chk(pa[2], pd[2]);
      run_op(NFC_OP_CHIP, 19'h0_0000, 16'h0000);
      check(rd, 16'hFFFF);
      read_chk(pa[2], 16'hFFFF);
      report_and_stop();
   end
endmodule // nfc_host_tb
